// ==== dsc_phy.sv ====
// Top of the DDR strobe capture PHY: read lanes, resync and write launch
`timescale 1ns/1ns
`default_nettype none

module dsc_phy
    import dsc_pkg::*;
#(
    parameter int NUM_GROUPS = 8
)
(
    // Clock and reset
    input  wire logic                                  CLK_I,
    input  wire logic                                  RST_I,
    // Mode
    input  wire logic                                  MODE_FAST_I,
    // Memory pins, read direction
    input  wire logic [NUM_GROUPS-1:0]                 DQS_I,
    input  wire logic [NUM_GROUPS*dsc_pkg::LANE_WIDTH-1:0] DQ_I,
    // Memory pins, write direction
    output logic [NUM_GROUPS-1:0]                      DQS_O,
    output logic [NUM_GROUPS-1:0]                      DQS_OE_O,
    output logic [NUM_GROUPS*dsc_pkg::LANE_WIDTH-1:0]  DQ_O,
    output logic [NUM_GROUPS-1:0]                      DQ_OE_O,
    output logic [NUM_GROUPS-1:0]                      DM_O,
    // Read data to core
    output dsc_pkg::dsc_beat_t [NUM_GROUPS-1:0]        RD_BEAT_O,
    output logic [NUM_GROUPS-1:0]                      RD_VALID_O,
    // Write data from core
    input  wire dsc_pkg::dsc_beat_t [NUM_GROUPS-1:0]   WR_BEAT_I,
    input  wire dsc_pkg::dsc_mask_t [NUM_GROUPS-1:0]   WR_MASK_I,
    input  wire logic                                  WR_VALID_I,
    input  wire logic                                  WR_LAST_I,
    output logic                                       WR_READY_O,
    output logic                                       WR_BUSY_O
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_GROUPS < 1 || NUM_GROUPS > MAX_GROUPS) begin : g_bad_groups
        $error("NUM_GROUPS must lie between 1 and 8");
    end
    if (1000 / (WR_PERIOD_CYC * CLK_PERIOD_NS) > MEM_CLK_MAX_MHZ) begin : g_bad_rate
        $error("Write clock exceeds the memory clock limit");
    end

    // ------------------------------------------------------------------
    // Mode select
    // ------------------------------------------------------------------
    // Mode is a static pin; it is resampled so a change lands cleanly
    logic [2:0]           mode_s_q;
    logic                 mode_fast_q;
    logic [DLY_WIDTH-1:0] delay_sel;

    always_ff @(posedge CLK_I) begin
        mode_s_q <= {mode_s_q[1:0], MODE_FAST_I};
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_fast_q <= 1'b0;
        end else if (mode_s_q[1] == mode_s_q[2]) begin
            mode_fast_q <= mode_s_q[2];
        end
    end

    assign delay_sel = mode_fast_q ? DLY_FAST_CYC : DLY_DDR_CYC;

    // ------------------------------------------------------------------
    // Read lanes and resynchronisation
    // ------------------------------------------------------------------
    dsc_beat_t [NUM_GROUPS-1:0] cap_beat;
    logic      [NUM_GROUPS-1:0] cap_valid;
    dsc_beat_t [NUM_GROUPS-1:0] rs_beat_q [RESYNC_STAGES];
    logic      [NUM_GROUPS-1:0] rs_valid_q [RESYNC_STAGES];

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_lane
        // Each strobe sees only its own eight data lines
        dsc_lane u_lane (
            .clk_i   (CLK_I),
            .rst_i   (RST_I),
            .dqs_i   (DQS_I[g]),
            .dq_i    (DQ_I[g*LANE_WIDTH +: LANE_WIDTH]),
            .delay_i (delay_sel),
            .beat_o  (cap_beat[g]),
            .valid_o (cap_valid[g])
        );
    end

    // Register stages keep capture flops apart from core logic placement
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int s = 0; s < RESYNC_STAGES; s++) begin
                rs_beat_q[s]  <= '0;
                rs_valid_q[s] <= '0;
            end
        end else begin
            rs_beat_q[0]  <= cap_beat;
            rs_valid_q[0] <= cap_valid;
            for (int s = 1; s < RESYNC_STAGES; s++) begin
                rs_beat_q[s]  <= rs_beat_q[s-1];
                rs_valid_q[s] <= rs_valid_q[s-1];
            end
        end
    end

    assign RD_BEAT_O  = rs_beat_q[RESYNC_STAGES-1];
    assign RD_VALID_O = rs_valid_q[RESYNC_STAGES-1];

    // ------------------------------------------------------------------
    // Write launch state machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DSC_WR_IDLE,
        DSC_WR_BURST,
        DSC_WR_POST
    } dsc_wr_state_t;

    dsc_wr_state_t              st_q, st_d;
    logic [CNT_WIDTH-1:0]       ph_q, ph_d;
    dsc_beat_t [NUM_GROUPS-1:0] beat_q, beat_d;
    dsc_mask_t [NUM_GROUPS-1:0] mask_q, mask_d;
    logic                       last_q, last_d;
    logic                       ready_q, ready_d;

    wire accept   = WR_VALID_I && ready_q;
    wire ph_end   = (ph_q == CNT_WIDTH'(WR_PERIOD_CYC - 1));
    wire ph_fall  = (ph_q >= CNT_WIDTH'(WR_DATA_FALL));
    wire ph_strb  = (ph_q >= CNT_WIDTH'(WR_STROBE_RISE)) &&
                    (ph_q <  CNT_WIDTH'(WR_STROBE_FALL));
    wire ph_pre   = (ph_q == CNT_WIDTH'(WR_PERIOD_CYC - 2));

    always_comb begin
        st_d    = st_q;
        ph_d    = ph_q + CNT_WIDTH'(1);
        beat_d  = beat_q;
        mask_d  = mask_q;
        last_d  = last_q;
        ready_d = 1'b0;
        unique case (st_q)
            DSC_WR_IDLE: begin
                ph_d    = '0;
                ready_d = !accept;
                if (accept) begin
                    st_d   = DSC_WR_BURST;
                    beat_d = WR_BEAT_I;
                    mask_d = WR_MASK_I;
                    last_d = WR_LAST_I;
                end
            end
            DSC_WR_BURST: begin
                // Next beat is offered one cycle before the period ends
                ready_d = ph_pre && !last_q;
                if (ph_end) begin
                    if (accept) begin
                        beat_d = WR_BEAT_I;
                        mask_d = WR_MASK_I;
                        last_d = WR_LAST_I;
                    end else begin
                        st_d = DSC_WR_POST;
                    end
                end
            end
            DSC_WR_POST: begin
                if (ph_end) begin
                    st_d    = DSC_WR_IDLE;
                    ready_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q    <= DSC_WR_IDLE;
            ph_q    <= '0;
            beat_q  <= '0;
            mask_q  <= '0;
            last_q  <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            ph_q    <= ph_d;
            beat_q  <= beat_d;
            mask_q  <= mask_d;
            last_q  <= last_d;
            ready_q <= ready_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin launch registers
    // ------------------------------------------------------------------
    // Phase counter stands in for the shifted write clock; data edges
    // sit a quarter period ahead of the outgoing strobe edges
    logic [NUM_GROUPS*LANE_WIDTH-1:0] dq_q;
    logic [NUM_GROUPS-1:0]            dm_q, dqs_q, dq_oe_q, dqs_oe_q;
    logic                             busy_q;
    logic [NUM_GROUPS*LANE_WIDTH-1:0] dq_sel;
    logic [NUM_GROUPS-1:0]            dm_sel;
    wire                              in_burst = (st_q == DSC_WR_BURST);
    wire                              driving  = (st_q != DSC_WR_IDLE);

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_sel
        assign dq_sel[g*LANE_WIDTH +: LANE_WIDTH] =
            ph_fall ? beat_q[g].fall : beat_q[g].rise;
        assign dm_sel[g] = ph_fall ? mask_q[g].mask_fall : mask_q[g].mask_rise;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dq_q     <= '0;
            dm_q     <= '0;
            dqs_q    <= '0;
            dq_oe_q  <= '0;
            dqs_oe_q <= '0;
            busy_q   <= 1'b0;
        end else begin
            dq_q     <= in_burst ? dq_sel : '0;
            dm_q     <= in_burst ? dm_sel : '0;
            dqs_q    <= {NUM_GROUPS{in_burst && ph_strb}};
            dq_oe_q  <= {NUM_GROUPS{in_burst}};
            dqs_oe_q <= {NUM_GROUPS{driving}};
            busy_q   <= driving;
        end
    end

    assign DQ_O       = dq_q;
    assign DM_O       = dm_q;
    assign DQS_O      = dqs_q;
    assign DQ_OE_O    = dq_oe_q;
    assign DQS_OE_O   = dqs_oe_q;
    assign WR_READY_O = ready_q;
    assign WR_BUSY_O  = busy_q;

endmodule

`default_nettype wire

// ==== dsc_pkg.sv ====
// Constants, types and helpers shared by the DDR strobe capture PHY
package dsc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int MAX_GROUPS   = 8;
    localparam int LANE_WIDTH   = 8;
    localparam int BEAT_WIDTH   = 2 * LANE_WIDTH;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int STROBE_PERIOD_NS = 125;
    localparam int MEM_CLK_MAX_MHZ  = 133;
    localparam int PHASE_DDR_DEG    = 90;
    localparam int PHASE_FAST_DEG   = 72;
    localparam int WR_PERIOD_CYC    = 8;
    localparam int WR_STROBE_RISE   = WR_PERIOD_CYC / 4;
    localparam int WR_STROBE_FALL   = 3 * WR_PERIOD_CYC / 4;
    localparam int WR_DATA_FALL     = WR_PERIOD_CYC / 2;
    localparam int DLY_WIDTH        = 3;
    localparam int CNT_WIDTH        = 3;
    localparam int RESYNC_STAGES    = 2;

    // Each delay rounds down, never below one cycle
    function automatic logic [DLY_WIDTH-1:0] phase_cyc(input int deg);
        int c;
        c = (STROBE_PERIOD_NS * deg) / (360 * CLK_PERIOD_NS);
        if (c < 1) begin
            c = 1;
        end
        return c[DLY_WIDTH-1:0];
    endfunction

    localparam logic [DLY_WIDTH-1:0] DLY_DDR_CYC  = phase_cyc(PHASE_DDR_DEG);
    localparam logic [DLY_WIDTH-1:0] DLY_FAST_CYC = phase_cyc(PHASE_FAST_DEG);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        DSC_MODE_DDR,
        DSC_MODE_FAST
    } dsc_mode_t;

    typedef struct packed {
        logic [LANE_WIDTH-1:0] rise;
        logic [LANE_WIDTH-1:0] fall;
    } dsc_beat_t;

    typedef struct packed {
        logic mask_rise;
        logic mask_fall;
    } dsc_mask_t;

endpackage

// ==== dsc_lane.sv ====
// One by-eight read capture lane driven by its own group strobe
`timescale 1ns/1ns
`default_nettype none

module dsc_lane
    import dsc_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Group pins
    input  wire logic                 dqs_i,
    input  wire logic [LANE_WIDTH-1:0] dq_i,
    // Control
    input  wire logic [DLY_WIDTH-1:0] delay_i,
    // Captured beat
    output dsc_beat_t                 beat_o,
    output logic                      valid_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0]            dqs_s_q;
    logic [LANE_WIDTH-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
    logic                  dqs_lvl_q;
    logic [DLY_WIDTH-1:0]  dly_q, dly_d;
    logic                  pend_rise_q, pend_rise_d;
    logic [LANE_WIDTH-1:0] rise_q;
    dsc_beat_t             beat_q;
    logic                  valid_q;

    wire dqs_agree = (dqs_s_q[1] == dqs_s_q[2]);
    wire dqs_edge  = dqs_agree && (dqs_s_q[2] != dqs_lvl_q);
    wire dly_fire  = (dly_q == DLY_WIDTH'(1));

    always_ff @(posedge clk_i) begin
        dqs_s_q <= {dqs_s_q[1:0], dqs_i};
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
        dq_s3_q <= dq_s2_q;
    end

    // ------------------------------------------------------------------
    // Strobe delay and both-edge capture
    // ------------------------------------------------------------------
    // Delay restarts on each strobe edge; it is shorter than half a period
    always_comb begin
        dly_d       = dly_q;
        pend_rise_d = pend_rise_q;
        if (dqs_edge) begin
            dly_d       = delay_i;
            pend_rise_d = dqs_s_q[2];
        end else if (dly_q != '0) begin
            dly_d = dly_q - DLY_WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dqs_lvl_q   <= 1'b0;
            dly_q       <= '0;
            pend_rise_q <= 1'b0;
            rise_q      <= '0;
            beat_q      <= '0;
            valid_q     <= 1'b0;
        end else begin
            if (dqs_agree) begin
                dqs_lvl_q <= dqs_s_q[2];
            end
            dly_q       <= dly_d;
            pend_rise_q <= pend_rise_d;
            valid_q     <= 1'b0;
            if (dly_fire && pend_rise_q) begin
                rise_q <= dq_s3_q;
            end
            if (dly_fire && !pend_rise_q) begin
                beat_q  <= '{rise: rise_q, fall: dq_s3_q};
                valid_q <= 1'b1;
            end
        end
    end

    assign beat_o  = beat_q;
    assign valid_o = valid_q;

endmodule

`default_nettype wire

// ==== dsc_phy_checker.sv ====
// Port assertions for the DDR strobe capture PHY
`timescale 1ns/1ns
`default_nettype none

module dsc_phy_checker
    import dsc_pkg::*;
#(
    parameter int NUM_GROUPS = 8
)
(
    // Clock and reset
    input wire logic                          CLK_I,
    input wire logic                          RST_I,
    // Write side
    input wire logic [NUM_GROUPS-1:0]         DQS_O,
    input wire logic [NUM_GROUPS-1:0]         DQS_OE_O,
    input wire logic [NUM_GROUPS-1:0]         DQ_OE_O,
    input wire logic [NUM_GROUPS-1:0]         DM_O,
    input wire logic                          WR_VALID_I,
    input wire logic                          WR_READY_O,
    input wire logic                          WR_BUSY_O,
    // Read side
    input wire dsc_pkg::dsc_beat_t [NUM_GROUPS-1:0] RD_BEAT_O,
    input wire logic [NUM_GROUPS-1:0]         RD_VALID_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_strobe_beat;
        DQS_O[0] [*4] ##1 !DQS_O[0];
    endsequence

    a_strobe_width: assert property ($rose(DQS_O[0]) |-> s_strobe_beat)
        else $error("write strobe width wrong");
    a_oe_launch: assert property (WR_VALID_I && WR_READY_O |-> ##[1:2] DQ_OE_O[0])
        else $error("output enable late after accept");
    a_busy_accept: assert property (WR_VALID_I && WR_READY_O |-> ##2 WR_BUSY_O)
        else $error("busy not raised after accept");
    a_strobe_in_oe: assert property (DQS_O[0] |-> DQS_OE_O[0] && DQ_OE_O[0])
        else $error("strobe driven outside enable");
    a_oe_groups: assert property (DQ_OE_O != 0 |-> &DQ_OE_O && DQS_OE_O == DQ_OE_O)
        else $error("group enables disagree");
    a_mask_burst: assert property (DM_O[0] |-> DQ_OE_O[0])
        else $error("mask driven outside burst");
    a_oe_whole: assert property ($fell(DQ_OE_O[0]) |-> $past(DQ_OE_O[0], 8))
        else $error("enable dropped inside a beat");
    a_rd_pulse: assert property (RD_VALID_O[0] |=> !RD_VALID_O[0])
        else $error("read valid longer than one cycle");
    a_rd_hold: assert property (!RD_VALID_O[0] |-> $stable(RD_BEAT_O[0]))
        else $error("read beat changed without valid");
endmodule

bind dsc_phy dsc_phy_checker #(.NUM_GROUPS(NUM_GROUPS)) u_dsc_phy_checker (
    .CLK_I(CLK_I), .RST_I(RST_I), .DQS_O(DQS_O), .DQS_OE_O(DQS_OE_O),
    .DQ_OE_O(DQ_OE_O), .DM_O(DM_O), .WR_VALID_I(WR_VALID_I), .WR_READY_O(WR_READY_O),
    .WR_BUSY_O(WR_BUSY_O), .RD_BEAT_O(RD_BEAT_O), .RD_VALID_O(RD_VALID_O)
);
`default_nettype wire

// ==== dsc_mem_model.sv ====
// Behavioural memory returning read bursts on each strobe group enabled by grp_en_i
`timescale 1ns/1ns
`default_nettype none

module dsc_mem_model #(
    parameter int NUM_GROUPS = 8
)
(
    // Burst request
    input  wire logic                  go_i,
    input  wire logic [7:0]            pat_i,
    input  wire logic [NUM_GROUPS-1:0] grp_en_i,
    // Read pins
    output logic [NUM_GROUPS-1:0]      dqs_o,
    output logic [NUM_GROUPS*8-1:0]    dq_o
);
    initial begin
        dqs_o = '0;
        dq_o = '0;
    end

    // Edge-aligned strobe; centring is the device's job
    always @(posedge go_i) begin
        #3;
        for (int b = 0; b < 2; b++) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                dq_o[8*g +: 8] = pat_i ^ 8'(16 * g + b);
            end
            dqs_o = grp_en_i;
            #62;
            dq_o = ~dq_o;
            dqs_o = '0;
            #63;
        end
        // Released bus shows the inverse; strobe parks low
        dq_o = ~dq_o;
    end
endmodule
`default_nettype wire

// ==== dsc_phy_bench.sv ====
// Self-checking bench for the DDR strobe capture PHY
`timescale 1ns/1ns
`default_nettype none

module dsc_phy_bench;
    import dsc_pkg::*;
    localparam int NG = 2;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               fast = 1'b0;
    logic               go = 1'b0;
    logic               wr_valid = 1'b0;
    logic               wr_last = 1'b0;
    logic               wr_ready, wr_busy;
    logic [7:0]         pat = 8'h00;
    logic [NG-1:0]      grp_en = '1;
    logic [NG-1:0]      dqs_in, dqs_out, dqs_oe, dq_oe, dm, rd_valid;
    logic [NG*8-1:0]    dq_in, dq_out;
    dsc_beat_t [NG-1:0] rd_beat;
    dsc_beat_t [NG-1:0] wr_beat = '0;
    dsc_mask_t [NG-1:0] wr_mask = '0;
    int                 miscompares = 0;
    int                 n_tests = 0;
    int                 lat[2];

    always #5 clk = ~clk;

    dsc_phy #(.NUM_GROUPS(NG)) u_dsc_phy (
        .CLK_I(clk), .RST_I(rst), .MODE_FAST_I(fast), .DQS_I(dqs_in), .DQ_I(dq_in),
        .DQS_O(dqs_out), .DQS_OE_O(dqs_oe), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .DM_O(dm),
        .RD_BEAT_O(rd_beat), .RD_VALID_O(rd_valid), .WR_BEAT_I(wr_beat), .WR_MASK_I(wr_mask),
        .WR_VALID_I(wr_valid), .WR_LAST_I(wr_last), .WR_READY_O(wr_ready), .WR_BUSY_O(wr_busy)
    );
    dsc_mem_model #(.NUM_GROUPS(NG)) u_dsc_mem_model (
        .go_i(go), .pat_i(pat), .grp_en_i(grp_en), .dqs_o(dqs_in), .dq_o(dq_in)
    );

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t value %h not %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] pat_byte(logic [7:0] p, int g, int b, int f);
        logic [7:0] r;
        r = p ^ 8'(16 * g + b);
        return (f != 0) ? ~r : r;
    endfunction

    task automatic report_and_stop;
        $display("mismatches %0d of %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic t_reset;
        int n;
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        chk_bit(wr_ready, 1'b0);
        chk_val(16'(dq_oe), 16'h0);
        rst <= 1'b0;
        n = 0;
        while (wr_ready !== 1'b1 && n++ < 4)
            @(posedge clk);
        chk_bit(wr_ready, 1'b1);
        repeat (4) @(posedge clk);
    endtask

    task automatic t_read(input logic f, input logic [7:0] p, output int lt);
        int n;
        @(posedge clk);
        fast <= f;
        pat <= p;
        repeat (6) @(posedge clk);
        go <= 1'b1;
        n = 0;
        for (int b = 0; b < 2; b++) begin
            @(negedge clk);
            while (rd_valid[0] !== 1'b1 && n++ < 60)
                @(negedge clk);
            if (b == 0)
                lt = n;
            chk_val(16'(rd_valid), 16'(grp_en));
            for (int g = 0; g < NG; g++)
                if (grp_en[g])
                    chk_val(rd_beat[g], {pat_byte(p, g, b, 0), pat_byte(p, g, b, 1)});
        end
        go <= 1'b0;
    endtask

    // Two beats back to back; the second is offered while the first is on the pins
    task automatic t_write;
        int n, m, hi;
        fork
            begin
                for (int b = 0; b < 2; b++) begin
                    for (int g = 0; g < NG; g++) begin
                        wr_beat[g] <= {pat_byte(8'h3c, g, b, 0), pat_byte(8'h3c, g, b, 1)};
                        wr_mask[g] <= {1'(g ^ b), ~1'(g ^ b)};
                    end
                    wr_valid <= 1'b1;
                    wr_last <= (b == 1);
                    n = 0;
                    @(posedge clk);
                    while (wr_ready !== 1'b1 && n++ < 20)
                        @(posedge clk);
                end
                wr_valid <= 1'b0;
                wr_last <= 1'b0;
            end
            begin
                m = 0;
                hi = 0;
                while (dq_oe[0] !== 1'b1 && m++ < 10)
                    @(negedge clk);
                for (int k = 0; k < 16; k++) begin
                    chk_val(16'(dq_oe), 16'(2 ** NG - 1));
                    for (int g = 0; g < NG; g++) begin
                        chk_val(16'(dq_out[8*g +: 8]), 16'(pat_byte(8'h3c, g, k / 8, k % 8 / 4)));
                        chk_bit(dm[g], 1'(g ^ (k / 8) ^ (k % 8 / 4)));
                    end
                    chk_bit(dqs_out[0], 1'(k % 8 >= WR_STROBE_RISE && k % 8 < WR_STROBE_FALL));
                    hi += int'(dqs_out[0]);
                    @(negedge clk);
                end
                chk_val(16'(hi), 16'h0008);
                chk_val(16'(dq_oe), 16'h0);
                chk_bit(dqs_oe[0], 1'b1);
                chk_bit(wr_busy, 1'b1);
                while (wr_busy !== 1'b0 && m++ < 40)
                    @(negedge clk);
                chk_bit(dqs_oe[0], 1'b0);
                chk_bit(wr_busy, 1'b0);
                chk_bit(wr_ready, 1'b1);
            end
        join
    endtask

    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        t_reset();
        t_read(1'b0, 8'h5a, lat[0]);
        t_read(1'b1, 8'hc3, lat[1]);
        chk_val(16'(lat[0] - lat[1]), 16'(DLY_DDR_CYC - DLY_FAST_CYC));
        grp_en = 2'b01;
        t_read(1'b1, 8'h0f, lat[1]);
        t_reset();
        t_write();
        report_and_stop();
    end
endmodule
`default_nettype wire
